/* hw/mpl_map.vh */
/*
 mark position latch window: constants for field positions,
 encodings and timing counts. assumes a 100 MHz clock.
*/
`ifndef MPL_MAP_VH
`define MPL_MAP_VH
// mark_function_select digits as 4-bit nibbles
`define MPL_FS_LATCH_DIGIT   3:0
`define MPL_FS_ROLL_DIGIT    7:4
`define MPL_FS_TOP_DIGIT     15:12
`define MPL_FS_LATCH_VAL     4'h0
`define MPL_FS_INTR_VAL      4'h1
`define MPL_FS_ROLL_ON       4'h1
// unit select codes
`define MPL_UNIT_MM          2'h0
`define MPL_UNIT_INCH        2'h1
`define MPL_UNIT_PULSE       2'h2
`define MPL_UNIT_DEGREE      2'h3
// limit scaling, thousandths
`define MPL_DIGIT_SCALE      32'h0000_03E8
`define MPL_DEG_SPAN         32'h0005_7E40
// capture deadline
`define MPL_CAPTURE_NS       400000
`define MPL_CLK_NS           10
// MPL_CAPTURE_NS over MPL_CLK_NS, sized for a 16-bit age counter
`define MPL_CAPTURE_CYCLES   16'h9C40
`endif

/* hw/mpl_limit_fold.v */
/*
 mpl_limit_fold: joins the high and low three-digit halves of one
 window limit into a signed value, and folds it into 0..359.999 for
 degree units. assumes halves are signed integers within +-999.
*/
`timescale 1ns/1ps
module mpl_limit_fold (
  // halves
  input  wire signed [15:0] high_digits_in,
  input  wire signed [15:0] low_digits_in,
  input  wire               degree_in,
  // joined limit
  output wire signed [31:0] limit_out
);
`include "mpl_map.vh"
  wire               mixed;
  wire signed [31:0] hi_abs;
  wire signed [31:0] lo_abs;
  wire signed [31:0] mag;
  wire signed [31:0] joined;
  wire signed [31:0] span;
  wire signed [31:0] rem;
  assign span   = `MPL_DEG_SPAN;
  assign hi_abs = high_digits_in[15] ? -{{16{high_digits_in[15]}},
                  high_digits_in} : {{16{high_digits_in[15]}},
                  high_digits_in};
  assign lo_abs = low_digits_in[15] ? -{{16{low_digits_in[15]}},
                  low_digits_in} : {{16{low_digits_in[15]}},
                  low_digits_in};
  assign mag    = hi_abs * $signed(`MPL_DIGIT_SCALE) + lo_abs;
  // a minus sign on either half, or on both, reads as a negative limit
  assign mixed  = high_digits_in[15] | low_digits_in[15];
  assign joined = mixed ? -mag : mag;
  // verilog % keeps the dividend sign, so negatives add one span
  assign rem    = joined % span;
  assign limit_out = !degree_in ? joined :
                     (rem < 0) ? rem + span : rem;
endmodule // mpl_limit_fold

/* hw/mpl_mark_latch.v */
/*
 mpl_mark_latch: mark detection for a positioning servo. captures
 position on mark edges inside a window, flags completion per edge,
 and issues the interrupt positioning distance swap.

 holds:
 - edge detection on the sampled mark level, one cycle of latency
 - the valid window, from two limits of two signed halves each,
   joined and folded in mpl_limit_fold
 - a linear window for mm, inch and pulse units, compared against
   the actual position, or against the travel from the start
   position while roll feed display is on
 - a degree window folded into one turn, wrapping through zero when
   the minus-side limit is the larger one
 - separate captured positions for rising and falling mark edges,
   each with a completion flag; a fall outside the window is
   remembered so that the next rise keeps the flags as they are
 - a sticky parameter alarm for inverted linear limits
 - the interrupt positioning swap of the remaining distance, a
   one-cycle load pulse with the new distance beside it
 - a monitor that reports a capture later than the fast-input
   deadline; capture is one cycle, so it only guards future edits

 outputs:
 - rise_position_out and fall_position_out hold the last captured
   positions until the next edge in the window or reset
 - the done flags are levels; a fall in the window sets its flag
   and clears the rise flag in the same cycle
 - parameter_error_alarm_out holds until reset, like a power cycle
 - distance_load_out is high for one cycle, with
   remaining_distance_out carrying the new distance in that cycle

 assumes:
 - every input synchronous to clock_in, one clock domain
 - rst_n_in synchronous and active low
 - settings held static between resets, except limit updates made
   in the consistent order; an inverted window on the way latches
   nothing and may raise the alarm, which holds until reset
 - limit halves signed integers within -999..999
 - positions in thousandths of the user unit, degrees included
 - the motion controller owns the deceleration profile; this block
   only hands it the new distance
 - the mark sensor is debounced upstream; every sampled change is
   taken as an edge
*/
`timescale 1ns/1ps
module mpl_mark_latch (
  // clock and reset
  input  wire               clock_in,
  input  wire               rst_n_in,
  // mark sensor and motion state
  input  wire               mark_input_in,
  input  wire signed [31:0] actual_position_in,
  input  wire signed [31:0] start_position_in,
  input  wire signed [31:0] remaining_distance_in,
  input  wire               home_return_in,
  input  wire               manual_mode_in,
  input  wire               motor_stopped_in,
  input  wire               temporary_stop_input_in,
  input  wire               reverse_rotation_in,
  // settings
  input  wire        [15:0] mark_function_select_in,
  input  wire         [1:0] unit_select_in,
  input  wire         [3:0] command_method_select_in,
  input  wire signed [15:0] range_plus_low_digits_in,
  input  wire signed [15:0] range_plus_high_digits_in,
  input  wire signed [15:0] range_minus_low_digits_in,
  input  wire signed [15:0] range_minus_high_digits_in,
  input  wire signed [31:0] mark_stop_distance_in,
  input  wire               fast_input_filter_select_in,
  input  wire               input_pin_assign_in,
  // results
  output reg  signed [31:0] rise_position_out,
  output reg  signed [31:0] fall_position_out,
  output reg                rise_latch_done_out,
  output reg                fall_latch_done_out,
  output reg                parameter_error_alarm_out,
  output reg                distance_load_out,
  output reg  signed [31:0] remaining_distance_out,
  output reg                capture_late_out
);
`include "mpl_map.vh"

////////////////////////////////////////////////////////////////////////
// limits
  localparam [15:0] CAP_CYCLES = `MPL_CAPTURE_CYCLES;
  // one-hot states; the default branch recovers from a stray code
  localparam [1:0]  ST_IDLE    = 2'b01;
  localparam [1:0]  ST_HIGH    = 2'b10;

  // limits and modes
  wire signed [31:0] plus_limit;
  wire signed [31:0] minus_limit;
  wire               degree;
  wire               latch_mode;
  wire               intr_mode;
  wire               roll_on;
  wire signed [31:0] compare_pos;
  wire signed [31:0] travel;
  wire signed [31:0] deg_pos;
  wire signed [31:0] deg_rem;
  wire signed [31:0] span;

  // window
  wire               limits_equal;
  wire               lin_window;
  wire               deg_straight;
  wire               deg_wrap;
  wire               deg_window;
  reg                in_window;

  // edge tracking
  reg                mark_prev;
  reg         [1:0]  state;
  reg         [1:0]  next_state;
  wire               rise;
  wire               fall;

  // qualifiers
  wire               rise_hit;
  wire               fall_hit;
  wire               fall_out;
  wire               limits_inverted;
  wire               intr_block;
  wire               intr_ok;
  wire               fast_capture;
  wire               capture_edge;

  // capture and deadline
  reg                fall_missed;
  reg         [15:0] edge_age;
  reg                edge_pending;

  assign degree = (unit_select_in == `MPL_UNIT_DEGREE);
  assign span   = `MPL_DEG_SPAN;

  mpl_limit_fold u_plus (
    .high_digits_in (range_plus_high_digits_in),
    .low_digits_in  (range_plus_low_digits_in),
    .degree_in      (degree),
    .limit_out      (plus_limit)
  );

  mpl_limit_fold u_minus (
    .high_digits_in (range_minus_high_digits_in),
    .low_digits_in  (range_minus_low_digits_in),
    .degree_in      (degree),
    .limit_out      (minus_limit)
  );

////////////////////////////////////////////////////////////////////////
// mode decode
  // interrupt positioning takes precedence over the latch digit
  assign latch_mode = (mark_function_select_in[`MPL_FS_LATCH_DIGIT] ==
                       `MPL_FS_LATCH_VAL) && !intr_mode;
  assign intr_mode  = (mark_function_select_in[`MPL_FS_TOP_DIGIT] ==
                       `MPL_FS_INTR_VAL);
  assign roll_on    = (mark_function_select_in[`MPL_FS_ROLL_DIGIT] ==
                       `MPL_FS_ROLL_ON);

  // absolute or incremental method does not change the window
  assign travel      = actual_position_in - start_position_in;
  assign compare_pos = roll_on ? travel
                               : actual_position_in;
  // degree positions fold into one turn before the compare
  assign deg_rem = compare_pos % span;
  assign deg_pos = (deg_rem < 0) ? deg_rem + span : deg_rem;

////////////////////////////////////////////////////////////////////////
// window check
  // rotation direction is deliberately not an input here
  assign limits_equal = (plus_limit == minus_limit);
  // linear units latch only with upper above lower, or with equal limits
  assign lin_window   = (plus_limit > minus_limit) &&
                        (compare_pos >= minus_limit) &&
                        (compare_pos <= plus_limit);
  assign deg_straight = (deg_pos >= minus_limit) &&
                        (deg_pos <= plus_limit);
  // minus side larger: window wraps through zero
  assign deg_wrap     = (deg_pos >= minus_limit) ||
                        (deg_pos <= plus_limit);
  assign deg_window   = (plus_limit > minus_limit) ? deg_straight
                                                   : deg_wrap;

  always @* begin
    if (limits_equal) begin
      in_window = 1'b1;
    end else if (degree) begin
      in_window = deg_window;
    end else begin
      in_window = lin_window;
    end
  end

////////////////////////////////////////////////////////////////////////
// edge tracking
  // mark_prev resets to the idle level, so reset brings no false edge
  assign rise = mark_input_in && !mark_prev;
  assign fall = !mark_input_in && mark_prev;

  always @* begin
    case (state)
      ST_IDLE: next_state = rise ? ST_HIGH : ST_IDLE;
      ST_HIGH: next_state = fall ? ST_IDLE : ST_HIGH;
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      mark_prev <= 1'b0;
      state     <= ST_IDLE;
    end else begin
      mark_prev <= mark_input_in;
      state     <= next_state;
    end
  end

////////////////////////////////////////////////////////////////////////
// position capture and flags
  // the latch, disabled in home return and manual operation
  wire latch_ok;
  assign latch_ok = latch_mode && !home_return_in && !manual_mode_in;

  // an edge counts only when it lands inside the window
  assign rise_hit = rise && in_window;
  assign fall_hit = fall && in_window;
  // a fall outside the window is remembered for the next rise
  assign fall_out = fall && !in_window;
  // degree limits always form a window, so only linear units alarm
  assign limits_inverted = !degree && (plus_limit < minus_limit);
  // the interrupt swap is refused in these motion states
  assign intr_block = home_return_in || manual_mode_in ||
                      motor_stopped_in || temporary_stop_input_in;
  assign intr_ok    = intr_mode && rise && !intr_block;
  // the deadline applies only on the fast input with its filter
  assign fast_capture = input_pin_assign_in &&
                        fast_input_filter_select_in;
  assign capture_edge = latch_ok && (rise_hit || fall_hit);

  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      rise_position_out   <= 32'sh0000_0000;
      fall_position_out   <= 32'sh0000_0000;
      rise_latch_done_out <= 1'b0;
      fall_latch_done_out <= 1'b0;
      fall_missed         <= 1'b0;
    end else if (latch_ok) begin
      if (rise_hit) begin
        rise_position_out <= actual_position_in;
        // flag stays as it was after an out-of-window fall
        if (!fall_missed) begin
          rise_latch_done_out <= 1'b1;
          fall_latch_done_out <= 1'b0;
        end
      end
      // edge outside window leaves stored value alone
      if (fall_hit) begin
        fall_position_out   <= actual_position_in;
        fall_latch_done_out <= 1'b1;
        rise_latch_done_out <= 1'b0;
        fall_missed         <= 1'b0;
      end else if (fall_out) begin
        fall_missed <= 1'b1;
      end
    end
  end

////////////////////////////////////////////////////////////////////////
// capture deadline monitor
  // capture is same-cycle; the counter only reports a breach
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      edge_age         <= 16'h0000;
      edge_pending     <= 1'b0;
      capture_late_out <= 1'b0;
    end else if (capture_edge) begin
      // age restarts at the edge and is read when the flag lands
      edge_pending <= 1'b1;
      edge_age     <= 16'h0000;
    end else if (edge_pending) begin
      edge_pending     <= 1'b0;
      capture_late_out <= capture_late_out |
                          (fast_capture && (edge_age >= CAP_CYCLES));
    end else begin
      // saturates so a long quiet spell never wraps back to zero
      edge_age <= (edge_age == 16'hFFFF) ? edge_age
                                         : edge_age + 16'h0001;
    end
  end

////////////////////////////////////////////////////////////////////////
// parameter alarm
  // software must order limit writes; a wrong order lands here
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      parameter_error_alarm_out <= 1'b0;
    end else if (limits_inverted) begin
      // sticky until reset, like a power cycle
      parameter_error_alarm_out <= 1'b1;
    end
  end

////////////////////////////////////////////////////////////////////////
// interrupt positioning
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      distance_load_out      <= 1'b0;
      remaining_distance_out <= 32'sh0000_0000;
    end else begin
      distance_load_out <= 1'b0;
      if (intr_ok) begin
        distance_load_out      <= 1'b1;
        remaining_distance_out <= mark_stop_distance_in;
      end else if (!distance_load_out) begin
        // pass-through lags the controller by one cycle
        remaining_distance_out <= remaining_distance_in;
      end
    end
  end

endmodule // mpl_mark_latch

/* dv/mpl_mark_latch_properties.sv */
/* checker for mpl_mark_latch flags, alarm and distance swap.
   assumes settings held static between resets. */
`timescale 1ns/1ps
module mpl_mark_latch_properties (
  input wire               clock_in,
  input wire               rst_n_in,
  input wire               mark_input_in,
  input wire        [15:0] mark_function_select_in,
  input wire signed [31:0] mark_stop_distance_in,
  input wire               rise_latch_done_out,
  input wire               fall_latch_done_out,
  input wire               parameter_error_alarm_out,
  input wire               distance_load_out,
  input wire signed [31:0] remaining_distance_out,
  input wire               capture_late_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  AST_FLAG_EXCL: assert property (!(rise_latch_done_out &&
    fall_latch_done_out)) else $error("both done flags high");
  AST_RISE_CAUSE: assert property ($rose(rise_latch_done_out)
    |-> $past(mark_input_in)) else $error("rise flag without mark");
  AST_FALL_CAUSE: assert property ($rose(fall_latch_done_out)
    |-> !$past(mark_input_in) && !rise_latch_done_out)
    else $error("fall flag without fall");
  AST_LATCH_SEL: assert property ($rose(rise_latch_done_out)
    |-> mark_function_select_in[3:0] == 4'h0 &&
    mark_function_select_in[15:12] != 4'h1) else $error("bad select");
  AST_ALARM_HOLD: assert property (parameter_error_alarm_out
    |=> parameter_error_alarm_out) else $error("alarm dropped");
  AST_LOAD_PULSE: assert property (distance_load_out
    |=> !distance_load_out) else $error("load too long");
  AST_LOAD_VALUE: assert property (distance_load_out |->
    remaining_distance_out == mark_stop_distance_in)
    else $error("wrong swapped distance");
  AST_LOAD_MODE: assert property (distance_load_out |->
    mark_function_select_in[15:12] == 4'h1) else $error("load mode");
  AST_NO_LATE: assert property (!capture_late_out)
    else $error("capture late");
  COV_RISE: cover property ($rose(rise_latch_done_out));
  COV_FALL: cover property ($rose(fall_latch_done_out));
  COV_LOAD: cover property (distance_load_out);
  COV_ALARM: cover property ($rose(parameter_error_alarm_out));
endmodule // mpl_mark_latch_properties
bind mpl_mark_latch mpl_mark_latch_properties u_props (.*);

/* dv/mpl_mark_sensor.sv */
/* mark sensor model on a digital input.
   assumes the bench calls drive between clock edges. */
`timescale 1ns/1ps
module mpl_mark_sensor (
  // clock
  input wire clock_in,
  // sensor level
  output reg mark_input_out
);
  initial mark_input_out = 1'b0;
  task drive(input reg level);
    begin
      @(posedge clock_in);
      mark_input_out <= level;
    end
  endtask
endmodule // mpl_mark_sensor

/* dv/mpl_mark_latch_bench.sv */
/* bench for mpl_mark_latch: windows, flags, alarm, swap.
   assumes one 100 MHz clock and the sensor model. */
`timescale 1ns/1ps
module mpl_mark_latch_bench;
  reg               clock_in = 0;
  reg               rst_n_in = 0;
  reg signed [31:0] pos = 0;
  reg        [3:0]  hold = 0;
  reg               rev = 0;
  reg        [15:0] fsel = 0;
  reg        [1:0]  unit = 0;
  reg signed [15:0] ph = 0, pl = 0, mh = 0, ml = 0;
  reg signed [31:0] start = 32'sh0001_86A0;
  reg signed [31:0] stop = 32'sh0000_04D2;
  wire              mark, rdone, fdone, alarm, load, late;
  wire signed [31:0] rpos, fpos, rdist;
  integer           errors = 0, samples_checked = 0, cycles = 0;
  integer           loads = 0;
  reg signed [31:0] last = 0;
  always #5 clock_in = ~clock_in;
  mpl_mark_sensor u_sen (.clock_in(clock_in), .mark_input_out(mark));
  mpl_mark_latch u_dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .mark_input_in(mark), .actual_position_in(pos),
    .start_position_in(start),
    .remaining_distance_in(32'sh0000_0063),
    .home_return_in(hold[0]), .manual_mode_in(hold[1]),
    .motor_stopped_in(hold[2]), .temporary_stop_input_in(hold[3]),
    .reverse_rotation_in(rev), .mark_function_select_in(fsel),
    .unit_select_in(unit), .command_method_select_in(4'h1),
    .range_plus_low_digits_in(pl), .range_plus_high_digits_in(ph),
    .range_minus_low_digits_in(ml), .range_minus_high_digits_in(mh),
    .mark_stop_distance_in(stop),
    .fast_input_filter_select_in(1'b1), .input_pin_assign_in(1'b1),
    .rise_position_out(rpos), .fall_position_out(fpos),
    .rise_latch_done_out(rdone), .fall_latch_done_out(fdone),
    .parameter_error_alarm_out(alarm), .distance_load_out(load),
    .remaining_distance_out(rdist), .capture_late_out(late));
  ////////////////////////////////////////////////////////////////
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (load) begin
      loads <= loads + 1;
      last <= rdist;
    end
    if (cycles == 5000) begin
      errors = errors + 1;
      complete_run;
    end
  end
  task complete_run;
    begin
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task check32(input signed [31:0] got, input signed [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("BAD %0t value %0d want %0d", $time, got, exp);
      end
    end
  endtask
  task check1(input got, input exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("BAD %0t flag %b want %b", $time, got, exp);
      end
    end
  endtask
  // limits only change under reset, so no transient inverted window
  task cfg(input [15:0] f, input [1:0] u,
           input signed [15:0] a, b, c, d);
    begin
      @(posedge clock_in);
      rst_n_in <= 0;
      fsel <= f; unit <= u; ph <= a; pl <= b; mh <= c; ml <= d;
      hold <= 0;
      u_sen.drive(1'b0);
      repeat (2) @(posedge clock_in);
      rst_n_in <= 1;
      repeat (2) @(posedge clock_in);
    end
  endtask
  task step(input v, input signed [31:0] p);
    begin
      @(posedge clock_in);
      pos <= p;
      u_sen.drive(v);
      repeat (3) @(posedge clock_in);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task t_linear;
    begin
      cfg(16'h0000, 2'h0, 500, 0, 300, 0);
      check1(alarm, 0);
      step(1, 400000);
      check32(rpos, 400000);
      check1(rdone, 1);
      step(0, 320000);
      check32(fpos, 320000);
      check1(fdone, 1);
      check1(rdone, 0);
      step(1, 700000);
      check32(rpos, 400000);
      check1(fdone, 1);
    end
  endtask
  task t_miss;
    begin
      cfg(16'h0000, 2'h2, 500, 0, 300, 0);
      step(1, 400000);
      step(0, 450000);
      step(1, 700000);
      step(0, 710000);
      check32(fpos, 450000);
      step(1, 420000);
      check32(rpos, 420000);
      check1(rdone, 0);
      check1(fdone, 1);
    end
  endtask
  task t_equal_roll;
    begin
      cfg(16'h0000, 2'h1, 0, 0, 0, 0);
      step(1, -5000);
      check32(rpos, -5000);
      cfg(16'h0010, 2'h0, 500, 0, 300, 0);
      step(1, 550000);
      check1(rdone, 1);
      step(0, 650000);
      check1(fdone, 0);
    end
  endtask
  // plus -270 folds to 90, window 315..90 wraps through zero
  task t_degree;
    begin
      cfg(16'h0000, 2'h3, -270, 0, 315, 0);
      rev <= 1;
      step(1, 10000);
      check1(rdone, 1);
      step(0, 350000);
      check1(fdone, 1);
      step(1, 180000);
      check1(rdone, 0);
      rev <= 0;
    end
  endtask
  task t_alarm;
    begin
      cfg(16'h0000, 2'h0, 5, -1, 0, 0);
      check1(alarm, 1);
      step(1, -3000);
      check1(rdone, 0);
      cfg(16'h0002, 2'h0, 0, 0, 0, 0);
      step(1, 1000);
      check1(rdone, 0);
    end
  endtask
  task t_intr;
    integer i;
    begin
      cfg(16'h1000, 2'h0, 0, 0, 0, 0);
      step(1, 1000);
      check1(rdone, 0);
      check32(loads, 1);
      check32(last, 1234);
      for (i = 0; i < 4; i = i + 1) begin
        step(0, 0);
        hold <= 4'h1 << i;
        step(1, 0);
        check32(loads, 1);
      end
      check32(rdist, 99);
      check1(late, 0);
    end
  endtask
  initial begin
    repeat (20) @(posedge clock_in);
    rst_n_in <= 1;
    t_linear;
    t_miss;
    t_equal_roll;
    t_degree;
    t_alarm;
    t_intr;
    complete_run;
  end
endmodule // mpl_mark_latch_bench
